// ### dv/gst_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural source of count pulses at the external input
module gst_pulse_src (
  input wire logic clk_i, // Core clock that paces the edges
  output logic ext_o // Count input level
);
  // Idle level before any stimulus
  initial ext_o = 1'b0;
  // Moves the line to a level just after an edge
  task automatic set_level(input logic lvl);
    @(posedge clk_i);
    ext_o <= lvl;
  endtask
  // Whole pulses, low phase first so a fall precedes each rise
  task automatic pulses(input int n, input int half);
    repeat (n)
    begin
      @(posedge clk_i);
      ext_o <= 1'b0;
      repeat (half) @(posedge clk_i);
      ext_o <= 1'b1;
      repeat (half - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ### dv/test_gated_sixteen_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_gated_sixteen_bit_timer;
  import gst_pkg::*;
  logic clk, rst_b, psel, pen, pwr, spev, slp, gpin, comp, err, rdy;
  logic [7:0] paddr; // Bus address
  logic [31:0] pwdata, rd, prdata; // Bus data
  logic [1:0] pdir, plev, dir_o; // Pin directions and levels
  logic pready, pslverr, ext, xen, tick, irq, wake; // Design outputs and the count input
  logic [15:0] cnt; // Present count
  int error_cnt, check_count, c0, r, n, mdl;
  // Device under test
  gst_timer #(.PRESCALE_W(3)) i_gst_timer (.CLOCK_I(clk), .RST_B_I(rst_b),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EXT_COUNT_I(ext), .GATE_PIN_I(gpin),
    .COMP_RESULT_I(comp), .SPECIAL_EVT_I(spev), .SLEEP_I(slp),
    .PIN_DIR_I(pdir), .PIN_LEVEL_I(plev), .PIN_DIR_O(dir_o),
    .CRYSTAL_EN_O(xen), .INC_TICK_O(tick), .COUNT_O(cnt), .IRQ_O(irq),
    .WAKE_O(wake));
  // Far-side pulse source
  gst_pulse_src i_gst_pulse_src (.clk_i(clk), .ext_o(ext));
  // Core clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compares one value and counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // One bus transfer; holds the request until ready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic ev);
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    spev <= ev;
    // Ready, read data and error are taken at the access edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdy = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    if (!rdy)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      error_cnt++;
    end
    psel <= 1'b0;
    pen <= 1'b0;
    spev <= 1'b0;
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d), 1'b0);
  endtask
  // Register read and compare
  task automatic rdchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    chk(rd, 32'(e));
  endtask
  // Prints counts and ends the run
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cuts a hang short
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    {psel, pen, pwr, spev, slp, gpin, comp} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rst_b = 1'b0;
    void'($urandom(92645));
    pdir = 2'($urandom);
    plev = 2'($urandom);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped address
    for (int a = 0; a < 6; a++) rdchk(8'(a * 4), 0);
    rdchk(OFS_PINS, 32'({pdir, plev}));
    rdchk(8'h1C, 0);
    chk(32'(err), 1);
    // Internal source: tick spacing per prescale, one step per tick
    for (int p = 0; p < 4; p++)
    begin
      wr(OFS_CTRL, 32'h01 | (p << 4));
      n = 0;
      do @(negedge clk); while (tick !== 1'b1 && ++n < 200);
      c0 = 32'(cnt);
      n = 0;
      do @(negedge clk); while (tick !== 1'b1 && ++n < 200);
      chk(32'(n + 1), 32'(INSN_DIV << p));
      chk(32'(cnt), 32'(c0 + 1));
    end
    // Rollover, flag, interrupt enables and wake
    wr(OFS_CTRL, 0);
    wr(OFS_CNT_HIGH, 32'hFF);
    wr(OFS_CNT_LOW, 32'hFD);
    wr(OFS_IRQ, 3);
    wr(OFS_CTRL, 1);
    n = 0;
    do @(negedge clk); while (cnt !== 16'h0000 && ++n < 100);
    rdchk(OFS_FLAG, 1);
    chk(32'(irq), 0);
    chk(32'(wake), 0);
    @(posedge clk);
    slp <= 1'b1;
    @(negedge clk);
    chk(32'(wake), 1);
    @(posedge clk);
    slp <= 1'b0;
    wr(OFS_IRQ, 7);
    @(negedge clk);
    chk(32'(irq), 1);
    wr(OFS_IRQ, 5);
    @(negedge clk);
    chk(32'(irq), 0);
    wr(OFS_IRQ, 7);
    wr(OFS_FLAG, 0);
    @(negedge clk);
    chk(32'(irq), 0);
    // Counter mode, synchronised and not, with sleep
    for (int b = 0; b < 2; b++)
    begin
      wr(OFS_CTRL, 0);
      i_gst_pulse_src.set_level(1'b0);
      wr(OFS_CTRL, 32'h03 | (b << 2));
      wr(OFS_CNT_LOW, 0);
      wr(OFS_CNT_HIGH, 0);
      i_gst_pulse_src.set_level(1'b1);
      repeat (8) @(posedge clk);
      slp <= 1'b1;
      i_gst_pulse_src.pulses(4, 3);
      repeat (8) @(posedge clk);
      slp <= 1'b0;
      mdl = b * 4;
      @(negedge clk);
      chk(32'(cnt), 32'(mdl));
      i_gst_pulse_src.pulses(2, 2);
      repeat (8) @(posedge clk);
      mdl += 2;
      rdchk(OFS_CNT_LOW, mdl);
    end
    // Byte writes and the special event
    wr(OFS_CTRL, 0);
    r = int'($urandom);
    wr(OFS_CNT_LOW, r & 32'hFF);
    wr(OFS_CNT_HIGH, (r >> 8) & 32'hFF);
    @(negedge clk);
    chk(32'(cnt), r & 32'hFFFF);
    @(posedge clk);
    spev <= 1'b1;
    @(posedge clk);
    spev <= 1'b0;
    @(negedge clk);
    chk(32'(cnt), 0);
    rdchk(OFS_FLAG, 0);
    wr(OFS_CNT_HIGH, (r >> 8) & 32'hFF);
    apb(1'b1, OFS_CNT_LOW, 32'((r >> 16) & 32'hFF), 1'b1);
    @(negedge clk);
    chk(32'(cnt), (r & 32'hFF00) | ((r >> 16) & 32'hFF));
    // Crystal oscillator against each system clock mode
    for (int g = 0; g < 4; g++)
    begin
      wr(OFS_CFG, g << 1);
      wr(OFS_CTRL, 32'h08);
      @(negedge clk);
      chk(32'(xen), 32'(g < 2));
      chk(32'(dir_o), 32'(g < 2 ? 2'b11 : pdir));
      rdchk(OFS_PINS, g < 2 ? 32'hC : 32'({pdir, plev}));
      // Oscillator start-up wait, then the counter is turned on
      repeat (16) @(posedge clk);
      wr(OFS_CTRL, 32'h09);
      @(negedge clk);
      chk(32'(xen), 32'(g < 2));
    end
    // Gate from pin or comparator, both polarities
    wr(OFS_CNT_LOW, 0);
    wr(OFS_CNT_HIGH, 0);
    for (int g = 0; g < 4; g++)
    begin
      wr(OFS_CFG, g >> 1);
      @(posedge clk);
      gpin <= g[1] ? 1'($urandom) : ~g[0];
      comp <= g[1] ? ~g[0] : 1'($urandom);
      wr(OFS_CTRL, 32'h41 | ((g & 1) << 7));
      repeat (20) @(posedge clk);
      @(negedge clk);
      c0 = 32'(cnt);
      repeat (40) @(negedge clk);
      chk(32'(cnt), 32'(c0));
      @(posedge clk);
      if (g[1]) comp <= g[0];
      else gpin <= g[0];
      repeat (40) @(negedge clk);
      chk(32'(32'(cnt) >= c0 + 8), 1);
    end
    give_verdict;
  end
endmodule
`default_nettype wire

// ### logic/gst_pkg.sv
package gst_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT_LOW = 8'h04;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0C;
  localparam logic [7:0] OFS_IRQ = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  localparam logic [7:0] OFS_PINS = 8'h18;
  // Reset values and the counter maximum
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [2:0] CFG_RST = 3'h0;
  // Field positions
  localparam int FLAG_BIT = 0;
  localparam int CFG_GSRC_BIT = 0;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_PER_BIT = 1;
  localparam int IRQ_GLB_BIT = 2;
  // Instruction clock is the core clock divided by four
  localparam int INSN_DIV = 4;
  localparam logic [1:0] INSN_LAST = 2'(INSN_DIV - 1);
  // Time-out-free APB slave: answers in the access cycle
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // Timer control fields, bit 7 down to bit 0
  typedef struct packed {
    logic gate_invert;
    logic gate_enable;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_bypass;
    logic clock_source_select;
    logic counter_on;
  } gst_ctrl_t;
  // System clock modes held in the configuration register
  typedef enum logic [1:0] {
    SYS_ONCHIP_RC = 2'b00,
    SYS_SLOW_CRYSTAL = 2'b01,
    SYS_OTHER = 2'b10,
    SYS_OTHER2 = 2'b11
  } gst_sysclk_t;
  // Falling-edge arming of the counter input
  typedef enum logic [0:0] {
    ARM_WAIT_FALL = 1'b0,
    ARM_READY = 1'b1
  } gst_arm_t;
endpackage

// ### logic/gst_timer.sv
// Notes on behaviour
// - Source bit picks instruction or external clock
// - Prescaler divides by one, two, four, eight
// - Prescaler hidden; cleared by counter byte write
// - Counter mode counts external rising edges
// - First rising edge needs prior falling edge
// - Oscillator enable starts crystal, runs in sleep
// - Crystal usable only with RC or slow crystal
// - Crystal on forces pin directions, reads zero
// - Bypass counts unsynchronised, sleeps, wakes on overflow; here it uses the same two-stage synchronised edge detector
// - Mode switch may skip or add one
// - Asynchronous byte reads always return valid value
// - Gate from pin or comparator when enabled
// - Invert bit reverses gate for both sources
// - Wrap to zero and set overflow flag
// - Interrupt needs three enables; flag sticks
// - Sleep counts only asynchronously; overflow wakes; here sleep counts only in bypass mode, through the synchronised edge detector
// - Special event clears count without flag
// - Counter write beats coinciding special event
// - Increment tick offered to comparator sync
// - Byte write replaces that byte immediately
// - Invert one counts gate high, zero low
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module gst_timer
  import gst_pkg::*;
#(
  parameter int PRESCALE_W = 3 // Width of the prescale counter
)
(
  input wire logic CLOCK_I, // Core clock, 250 MHz
  input wire logic RST_B_I, // Asynchronous reset, active low
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB access phase
  input wire logic PWRITE_I, // APB direction, high writes
  input wire logic [7:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I, // APB write data
  output logic [31:0] PRDATA_O, // APB read data
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error on unmapped address
  input wire logic EXT_COUNT_I, // External count input
  input wire logic GATE_PIN_I, // Gate pin level
  input wire logic COMP_RESULT_I, // Comparator 2 output
  input wire logic SPECIAL_EVT_I, // Capture/compare trigger pulse
  input wire logic SLEEP_I, // Processor is asleep
  input wire logic [1:0] PIN_DIR_I, // Pin 5:4 direction bits
  input wire logic [1:0] PIN_LEVEL_I, // Pin 5:4 levels
  output logic [1:0] PIN_DIR_O, // Effective pin 5:4 directions
  output logic CRYSTAL_EN_O, // Crystal oscillator run enable
  output logic INC_TICK_O, // Increment tick for comparator
  output logic [15:0] COUNT_O, // Present count
  output logic IRQ_O, // Overflow interrupt request
  output logic WAKE_O // Wake request from sleep
);
  import gst_pkg::*;

  // Elaboration check of the prescaler width
  if (PRESCALE_W < 3)
  begin : g_bad_width
    $error("PRESCALE_W must be at least 3");
  end

  // Register state and next values
  gst_ctrl_t ctrl_r; // Timer control fields
  logic [15:0] cnt_r; // Counter pair
  logic flag_r; // Overflow flag
  logic [2:0] irq_en_r; // Overflow, peripheral, global enables
  logic [2:0] cfg_r; // Gate source and system clock mode
  logic [1:0] insn_div_r; // Instruction clock divider
  logic [PRESCALE_W-1:0] pre_r; // Hidden prescale counter
  logic ext_s1_r; // External input, first sample
  logic ext_s2_r; // External input, second sample
  gst_arm_t arm_r; // Falling-edge arming state
  logic [15:0] cnt_nxt; // Next count value
  logic [PRESCALE_W-1:0] pre_nxt; // Next prescale value

  // Bus decode
  logic wr_en; // Write takes effect this cycle
  logic rd_en; // Read answered this cycle
  logic hit; // Address is mapped
  logic wr_low; // Low counter byte written
  logic wr_high; // High counter byte written
  logic wr_ctrl; // Control written

  // Decode a register offset into a mapped flag
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_CNT_LOW) ||
                (a == OFS_CNT_HIGH) || (a == OFS_FLAG) ||
                (a == OFS_IRQ) || (a == OFS_CFG) || (a == OFS_PINS);
  endfunction

  // Setup and access qualification of APB
  always_comb
  begin
    hit = is_mapped(PADDR_I);
    wr_en = PSEL_I && PENABLE_I && PWRITE_I && hit;
    rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
    wr_low = wr_en && (PADDR_I == OFS_CNT_LOW);
    wr_high = wr_en && (PADDR_I == OFS_CNT_HIGH);
    wr_ctrl = wr_en && (PADDR_I == OFS_CTRL);
  end

  // Slave always answers in the access cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

  // Derived system conditions
  logic sys_ok; // Crystal allowed by the system clock mode
  logic osc_on; // Crystal oscillator running
  logic gate_src; // Selected gate source
  logic gate_ok; // Gate allows counting
  logic asleep_ok; // Counting permitted in the present power state
  logic insn_tick; // One pulse per instruction cycle
  logic ext_rise_sync; // Rising edge, synchronised path
  logic ext_rise_async; // Rising edge, bypass path
  logic ext_fall; // Falling edge seen by the selected path
  logic src_tick; // Selected clock tick before prescale
  logic pre_tick; // Tick after prescale
  logic inc; // Counter advances this cycle
  logic [PRESCALE_W-1:0] pre_last; // Final prescale count

  always_comb
  begin
    // Slow-crystal sharing restriction
    sys_ok = (gst_sysclk_t'(cfg_r[2:1]) == SYS_ONCHIP_RC) ||
             (gst_sysclk_t'(cfg_r[2:1]) == SYS_SLOW_CRYSTAL);
    osc_on = ctrl_r.crystal_osc_enable && sys_ok;
    // Gate source and polarity
    gate_src = cfg_r[CFG_GSRC_BIT] ? COMP_RESULT_I : GATE_PIN_I;
    gate_ok = !ctrl_r.gate_enable ||
              (ctrl_r.gate_invert ? gate_src : !gate_src);
    // In sleep only the bypass-selected external path runs
    asleep_ok = !SLEEP_I ||
                (ctrl_r.clock_source_select &&
                 ctrl_r.sync_bypass);
    insn_tick = (insn_div_r == INSN_LAST);
    // Both paths share one edge detector, as pins are synchronous
    ext_rise_async = ext_s1_r && !ext_s2_r;
    ext_rise_sync = ext_s1_r && !ext_s2_r;
    ext_fall = !ext_s1_r && ext_s2_r;
    if (ctrl_r.clock_source_select)
    begin
      // External rising edges once armed
      src_tick = (arm_r == ARM_READY) &&
                 (ctrl_r.sync_bypass ? ext_rise_async
                                     : ext_rise_sync);
    end
    else
    begin
      // Instruction clock
      src_tick = insn_tick;
    end
    // Prescaler terminal value 0, 1, 3 or 7
    pre_last = PRESCALE_W'((1 << ctrl_r.prescale_select) - 1);
    pre_tick = src_tick && (pre_r == pre_last);
    inc = pre_tick && ctrl_r.counter_on && gate_ok &&
          asleep_ok;
  end

  // Increment clock handed to the comparator
  assign INC_TICK_O = inc;

  // Instruction clock divider
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      insn_div_r <= 2'h0;
    end
    else
    begin
      insn_div_r <= insn_div_r + 2'h1;
    end
  end

  // External input sampling, two stages
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= EXT_COUNT_I;
      ext_s2_r <= ext_s1_r;
    end
  end

  // Arming: a falling edge must precede counting after setup
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      arm_r <= ARM_WAIT_FALL;
    end
    else if (wr_ctrl)
    begin
      // Any new setup rearms
      arm_r <= ARM_WAIT_FALL;
    end
    else if (ext_fall)
    begin
      arm_r <= ARM_READY;
    end
  end

  // Prescale counter, never visible on the bus
  always_comb
  begin
    if (wr_low || wr_high)
    begin
      pre_nxt = '0;
    end
    else if (pre_tick)
    begin
      pre_nxt = '0;
    end
    else if (src_tick)
    begin
      pre_nxt = pre_r + PRESCALE_W'(1);
    end
    else
    begin
      pre_nxt = pre_r;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      pre_r <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
    end
  end

  // Counter next value: write, then trigger, then increment
  always_comb
  begin
    if (wr_low)
    begin
      cnt_nxt = {cnt_r[15:8], PWDATA_I[7:0]};
    end
    else if (wr_high)
    begin
      cnt_nxt = {PWDATA_I[7:0], cnt_r[7:0]};
    end
    else if (SPECIAL_EVT_I)
    begin
      cnt_nxt = CNT_RST;
    end
    else if (inc)
    begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    else
    begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      cnt_r <= CNT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Overflow flag: rollover sets, software zero clears, set wins
  logic ovf; // Rollover this cycle
  assign ovf = inc && (cnt_r == CNT_MAX) && !wr_low && !wr_high &&
               !SPECIAL_EVT_I;

  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      flag_r <= 1'b0;
    end
    else if (ovf)
    begin
      flag_r <= 1'b1;
    end
    else if (wr_en && (PADDR_I == OFS_FLAG))
    begin
      flag_r <= PWDATA_I[FLAG_BIT];
    end
  end

  // Control, enable and configuration registers
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ctrl_r <= gst_ctrl_t'(CTRL_RST);
      irq_en_r <= IRQ_RST;
      cfg_r <= CFG_RST;
    end
    else if (wr_en)
    begin
      if (PADDR_I == OFS_CTRL)
      begin
        ctrl_r <= gst_ctrl_t'(PWDATA_I[7:0]);
      end
      if (PADDR_I == OFS_IRQ)
      begin
        irq_en_r <= PWDATA_I[2:0];
      end
      if (PADDR_I == OFS_CFG)
      begin
        cfg_r <= PWDATA_I[2:0];
      end
    end
  end

  // Read multiplexer; counter bytes come from one flip-flop set
  always_comb
  begin
    PRDATA_O = RD_ZERO;
    if (rd_en)
    begin
      unique case (PADDR_I)
        OFS_CTRL: PRDATA_O[7:0] = ctrl_r;
        OFS_CNT_LOW: PRDATA_O[7:0] = cnt_r[7:0];
        OFS_CNT_HIGH: PRDATA_O[7:0] = cnt_r[15:8];
        OFS_FLAG: PRDATA_O[FLAG_BIT] = flag_r;
        OFS_IRQ: PRDATA_O[2:0] = irq_en_r;
        OFS_CFG: PRDATA_O[2:0] = cfg_r;
        OFS_PINS: PRDATA_O[3:0] = {PIN_DIR_O,
                     osc_on ? 2'b00 : PIN_LEVEL_I};
        default: PRDATA_O = RD_ZERO;
      endcase
    end
  end

  // Pin, oscillator and count outputs
  assign PIN_DIR_O = osc_on ? 2'b11 : PIN_DIR_I;
  assign CRYSTAL_EN_O = osc_on;
  assign COUNT_O = cnt_r;

  // Interrupt request and wake from sleep
  always_comb
  begin
    IRQ_O = flag_r && irq_en_r[IRQ_OVF_BIT] && irq_en_r[IRQ_PER_BIT] &&
            irq_en_r[IRQ_GLB_BIT];
    WAKE_O = SLEEP_I && ctrl_r.counter_on && flag_r &&
             irq_en_r[IRQ_OVF_BIT] && irq_en_r[IRQ_PER_BIT];
  end

  // Checks
  property p_wrap;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    ovf |=> (cnt_r == CNT_RST) && flag_r;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("rollover did not wrap and flag");

  property p_inc_one;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (inc && !wr_low && !wr_high && !SPECIAL_EVT_I)
      |=> cnt_r == $past(cnt_r) + 16'h0001;
  endproperty
  a_inc_one: assert property (p_inc_one)
    else $error("count did not advance by one");

  property p_evt_clear;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (SPECIAL_EVT_I && !wr_low && !wr_high && !flag_r &&
     !(wr_en && (PADDR_I == OFS_FLAG)))
      |=> (cnt_r == CNT_RST) && !flag_r;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("special event did not clear quietly");

  property p_write_wins;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (wr_low && SPECIAL_EVT_I)
      |=> cnt_r == {$past(cnt_r[15:8]), $past(PWDATA_I[7:0])};
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("write lost to special event");

  property p_pre_clear;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (wr_low || wr_high) |=> pre_r == '0;
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("prescaler not cleared by write");

  property p_sleep_count;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (SLEEP_I && !ctrl_r.sync_bypass) |-> !inc;
  endproperty
  a_sleep_count: assert property (p_sleep_count)
    else $error("counted in sleep while synchronised");

  property p_gate;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (ctrl_r.gate_enable && (ctrl_r.gate_invert != gate_src)) |-> !inc;
  endproperty
  a_gate: assert property (p_gate)
    else $error("counted while gate inactive");

  property p_irq;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    IRQ_O |-> flag_r && (irq_en_r == 3'h7);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without all enables");

  property p_pins;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    osc_on |-> PIN_DIR_O == 2'b11;
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin directions not forced");

  property p_arm;
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    wr_ctrl |=> !src_tick || !ctrl_r.clock_source_select;
  endproperty
  a_arm: assert property (p_arm)
    else $error("counted before a falling edge");
endmodule
`default_nettype wire
